// file: verilog/cfd_pkg.sv
package cfd_pkg;

  // Word layout
  localparam int WORD_W        = 32;
  localparam int PAIR_W        = 64;
  localparam int ADDR_LSB      = 0;
  localparam int ADDR_W        = 24;
  localparam int TSEL_LSB      = 24;
  localparam int TSEL_W        = 3;
  localparam int VALUE_LSB     = 0;
  localparam int VALUE_W       = 10;
  localparam int RSRC_LSB      = 16;
  localparam int RSRC_W        = 5;
  localparam int SIGN_BIT      = 25;
  localparam int VIM_LSB       = 26;
  localparam int RIM_LSB       = 28;
  localparam int WSOP_LSB      = 30;
  localparam int MODE_W        = 2;
  localparam int POP_LSB       = 0;
  localparam int POP_W         = 3;
  localparam int CONST_LSB     = 3;
  localparam int CONST_W       = 5;
  localparam int TEST_LSB      = 8;
  localparam int COUNT_LSB     = 10;
  localparam int COUNT_W       = 6;
  localparam int VPM_BIT       = 20;
  localparam int EOP_BIT       = 21;
  localparam int OPC_LSB       = 22;
  localparam int OPC_W         = 8;
  localparam int WQM_BIT       = 30;
  localparam int BAR_BIT       = 31;

  // Address shifts: field holds byte bits from bit 3 upward
  localparam int ADDR_SHIFT    = 3;
  localparam int BYTE_ADDR_W   = 35;
  localparam int CLAUSE_ADDR_W = 27;
  localparam int FETCH_ALIGN   = 16;

  // Call nesting
  localparam int CALL_DEPTH_MAX = 32;
  localparam int DEPTH_W        = 6;

  // Opcodes of interest
  localparam logic [7:0] OPC_NOP        = 8'h00;
  localparam logic [7:0] OPC_TEX_CLAUSE = 8'h01;
  localparam logic [7:0] OPC_VTX_CLAUSE = 8'h02;
  localparam logic [7:0] OPC_SHR_CLAUSE = 8'h03;
  localparam logic [7:0] OPC_CALL       = 8'h12;
  localparam logic [7:0] OPC_EMIT       = 8'h15;
  localparam logic [7:0] OPC_EMIT_CUT   = 8'h16;
  localparam logic [7:0] OPC_CUT        = 8'h17;
  localparam logic [7:0] OPC_TEX_ACK    = 8'h1B;
  localparam logic [7:0] OPC_VTX_ACK    = 8'h1C;
  localparam logic [7:0] OPC_TABLE_JUMP = 8'h1D;
  localparam logic [7:0] OPC_WAVE_SYNC  = 8'h1E;

  // Table source encodings
  localparam logic [2:0] TSEL_CONST_A = 3'h0;
  localparam logic [2:0] TSEL_CONST_D = 3'h3;
  localparam logic [2:0] TSEL_INDEX0  = 3'h4;
  localparam logic [2:0] TSEL_INDEX1  = 3'h5;

  // Field reset value
  localparam logic [PAIR_W-1:0] PAIR_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    test_active_pixels, test_never_pass, test_boolean_true, test_boolean_false
  } cfd_test_t;

  typedef enum logic [1:0] {
    semaphore_signal, semaphore_wait, wavefront_barrier_op, resource_initialise_op
  } cfd_wsop_t;

  typedef enum logic [1:0] {
    load_from_instr, load_from_index0, load_from_index1, load_from_mix
  } cfd_vim_t;

  typedef enum logic [1:0] {
    rsrc_no_index, rsrc_add_index0, rsrc_add_index1, rsrc_invalid
  } cfd_rim_t;

endpackage

// file: verilog/cfd_decoder.sv
// What this block does
// [RULE_01] Decode each instruction as 64-bit low/high pair
// [RULE_02] Clause start: low bits 23:0 are byte 26:3
// [RULE_03] Jump target: same field is byte 34:3; code places it at byte 26:3
// [RULE_04] Offsets added to program base register
// [RULE_05] Producer aligns fetch clauses to 16 bytes
// [RULE_06] Table source select: constants A-D, index0, index1
// [RULE_07] Fields default zero; unassigned bits reserved
// [RULE_08] Wave-sync bits 9:0 give counter load value
// [RULE_09] Wave-sync bits 20:16 give resource index
// [RULE_10] Bit 25 makes counter signed, else unsigned
// [RULE_11] Bits 27:26 choose counter load value source
// [RULE_12] Bits 29:28 add index register to resource
// [RULE_13] Bits 31:30 select atomic resource operation
// [RULE_14] High bits 2:0 give stack pop count
// [RULE_15] High bits 7:3 select flow constant
// [RULE_16] High bits 9:8 select per-pixel condition test
// [RULE_17] Clause length is count field plus one
// [RULE_18] Call adds count; skip if depth exceeds 32; code adds count bits 14:10 only
// [RULE_19] Emit/cut opcodes read bit 10 as stream
// [RULE_20] Bit 20 treats invalid pixels as inactive
// [RULE_21] Bit 21 marks last instruction, ends program
// [RULE_22] Bit 30 forces all lanes active and valid
// [RULE_23] Bit 31 waits for earlier instructions
// [RULE_24] Opcode in high bits 29:22
// [RULE_25] Wave-sync low layout only for sync opcode
// [RULE_26] Flag invalid override and unassigned table select
`timescale 1ns/1ns
`default_nettype none

module cfd_decoder
  import cfd_pkg::*;
#(
  parameter int SHADER_ENGINES = 1
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Instruction in
  input  wire logic                  instr_valid,
  input  wire logic [WORD_W-1:0]     flow_low_word,
  input  wire logic [WORD_W-1:0]     flow_high_word,
  input  wire logic [BYTE_ADDR_W-1:0] program_base_register,
  input  wire logic [DEPTH_W-1:0]    call_depth,
  // Decoded common fields
  output logic                       dec_valid,
  output logic [OPC_W-1:0]           flow_opcode,
  output logic [POP_W-1:0]           pop_count,
  output logic [CONST_W-1:0]         flow_constant_select,
  output cfd_test_t                  pixel_test_select,
  output logic [COUNT_W-1:0]         count_raw,
  output logic [COUNT_W:0]           clause_length,
  output logic                       stream_id,
  output logic                       valid_pixel_mode,
  output logic                       final_instruction_flag,
  output logic                       all_lanes_forced,
  output logic                       barrier_wait,
  output logic                       program_end,
  output logic                       call_skip,
  output logic [DEPTH_W-1:0]         call_depth_next,
  // Default low word
  output logic [BYTE_ADDR_W-1:0]     clause_address,
  output logic [BYTE_ADDR_W-1:0]     jump_address,
  output logic [TSEL_W-1:0]          table_source_select,
  output logic                       table_uses_const,
  output logic [1:0]                 table_const_element,
  output logic                       table_uses_index,
  output logic                       table_index_sel,
  // Wave-sync low word
  output logic                       wave_sync_valid,
  output logic [VALUE_W-1:0]         load_value,
  output logic                       value_signed,
  output logic [RSRC_W-1:0]          resource_index,
  output cfd_vim_t                   load_value_override,
  output cfd_rim_t                   resource_index_override,
  output cfd_wsop_t                  wave_sync_operation,
  // Diagnostics
  output logic                       illegal_encoding,
  output logic                       fetch_misaligned,
  output logic                       mode_conflict
);

  initial begin
    if (SHADER_ENGINES < 1 || SHADER_ENGINES > 2) begin
      $error("SHADER_ENGINES must be 1 or 2");
    end
    // Field layout must fit its word and keep fields apart
    if (PAIR_W != 2 * WORD_W) begin
      $error("pair must be two words");
    end
    if (ADDR_LSB + ADDR_W > TSEL_LSB) begin
      $error("address field overlaps table select");
    end
    if (TSEL_LSB + TSEL_W > WORD_W) begin
      $error("table select outside low word");
    end
    if (VALUE_LSB + VALUE_W > RSRC_LSB) begin
      $error("load value overlaps resource index");
    end
    if (RSRC_LSB + RSRC_W > SIGN_BIT) begin
      $error("resource index overlaps sign bit");
    end
    if (SIGN_BIT >= VIM_LSB) begin
      $error("sign bit overlaps load override");
    end
    if (VIM_LSB + MODE_W > RIM_LSB) begin
      $error("load override overlaps resource override");
    end
    if (RIM_LSB + MODE_W > WSOP_LSB) begin
      $error("resource override overlaps sync operation");
    end
    if (WSOP_LSB + MODE_W > WORD_W) begin
      $error("sync operation outside low word");
    end
    if (POP_LSB + POP_W > CONST_LSB) begin
      $error("pop count overlaps constant select");
    end
    if (CONST_LSB + CONST_W > TEST_LSB) begin
      $error("constant select overlaps pixel test");
    end
    if (TEST_LSB + MODE_W > COUNT_LSB) begin
      $error("pixel test overlaps count");
    end
    if (COUNT_LSB + COUNT_W > VPM_BIT) begin
      $error("count overlaps valid pixel bit");
    end
    if (VPM_BIT >= EOP_BIT) begin
      $error("valid pixel bit overlaps final bit");
    end
    if (EOP_BIT >= OPC_LSB) begin
      $error("final bit overlaps opcode");
    end
    if (OPC_LSB + OPC_W > WQM_BIT) begin
      $error("opcode overlaps forced lanes bit");
    end
    if (WQM_BIT >= BAR_BIT) begin
      $error("forced lanes bit overlaps barrier bit");
    end
    if (BAR_BIT >= WORD_W) begin
      $error("barrier bit outside high word");
    end
    if (ADDR_W + ADDR_SHIFT > BYTE_ADDR_W) begin
      $error("jump offset wider than byte address");
    end
    if (CLAUSE_ADDR_W > BYTE_ADDR_W) begin
      $error("clause offset wider than byte address");
    end
    if ((1 << DEPTH_W) <= CALL_DEPTH_MAX) begin
      $error("call depth too narrow for nesting limit");
    end
    if (FETCH_ALIGN < 2 || (FETCH_ALIGN & (FETCH_ALIGN - 1)) != 0) begin
      $error("fetch alignment not a power of two");
    end
  end

  typedef struct packed {
    logic                   valid;
    logic [OPC_W-1:0]       opc;
    logic [POP_W-1:0]       pop;
    logic [CONST_W-1:0]     cnst;
    cfd_test_t              test;
    logic [COUNT_W-1:0]     cnt;
    logic [COUNT_W:0]       len;
    logic                   stream;
    logic                   vpm;
    logic                   eop;
    logic                   wqm;
    logic                   bar;
    logic                   pend;
    logic                   cskip;
    logic [DEPTH_W-1:0]     cdepth;
    logic [BYTE_ADDR_W-1:0] caddr;
    logic [BYTE_ADDR_W-1:0] jaddr;
    logic [TSEL_W-1:0]      tsel;
    logic                   tconst;
    logic [1:0]             telem;
    logic                   tidx;
    logic                   tidx_sel;
    logic                   ws;
    logic [VALUE_W-1:0]     val;
    logic                   sgn;
    logic [RSRC_W-1:0]      rsrc;
    cfd_vim_t               vim;
    cfd_rim_t               rim;
    cfd_wsop_t              wsop;
    logic                   illegal;
    logic                   misalign;
    logic                   conflict;
  } cfd_state_t;

  cfd_state_t state_reg;
  cfd_state_t state_next;

  logic [PAIR_W-1:0]        pair;
  logic [OPC_W-1:0]         opc;
  logic                     is_sync;
  logic                     is_fetch;
  logic [ADDR_W-1:0]        addr_fld;
  logic [BYTE_ADDR_W-1:0]   clause_off;
  logic [BYTE_ADDR_W-1:0]   jump_off;
  logic [DEPTH_W:0]         depth_sum;
  logic [RSRC_W-1:0]        rsrc_fld;

  always_comb begin
    pair       = {flow_high_word, flow_low_word};  // see [RULE_01]
    opc        = pair[WORD_W+OPC_LSB +: OPC_W];    // see [RULE_24]
    is_sync    = (opc == OPC_WAVE_SYNC);           // see [RULE_25]
    is_fetch   = (opc == OPC_TEX_CLAUSE) || (opc == OPC_VTX_CLAUSE)
              || (opc == OPC_TEX_ACK) || (opc == OPC_VTX_ACK);
    addr_fld   = flow_low_word[ADDR_LSB +: ADDR_W];
    // Clause offsets only span byte bits 26:3
    clause_off = BYTE_ADDR_W'({addr_fld, ADDR_SHIFT'(0)}) &  // see [RULE_02]
                 BYTE_ADDR_W'((36'h1 << CLAUSE_ADDR_W) - 36'h1);
    jump_off   = BYTE_ADDR_W'({addr_fld, ADDR_SHIFT'(0)});    // see [RULE_03]
    depth_sum  = {1'b0, call_depth} + (DEPTH_W+1)'(flow_high_word[COUNT_LSB +: CONST_W]);
    rsrc_fld   = flow_low_word[RSRC_LSB +: RSRC_W];

    state_next = state_reg;
    state_next.valid = instr_valid;
    if (srst) begin
      state_next = cfd_state_t'(PAIR_RESET);  // see [RULE_07]
    end else if (instr_valid) begin
      state_next.opc    = opc;
      state_next.pop    = flow_high_word[POP_LSB +: POP_W];      // see [RULE_14]
      state_next.cnst   = flow_high_word[CONST_LSB +: CONST_W];  // see [RULE_15]
      state_next.test   = cfd_test_t'(flow_high_word[TEST_LSB +: MODE_W]);  // see [RULE_16]
      state_next.cnt    = flow_high_word[COUNT_LSB +: COUNT_W];
      state_next.len    = {1'b0, state_next.cnt} + 7'h01;        // see [RULE_17]
      state_next.stream = ((opc == OPC_EMIT) || (opc == OPC_CUT) || (opc == OPC_EMIT_CUT))
                          && flow_high_word[COUNT_LSB];          // see [RULE_19]
      state_next.vpm    = flow_high_word[VPM_BIT];               // see [RULE_20]
      state_next.eop    = flow_high_word[EOP_BIT];
      state_next.pend   = flow_high_word[EOP_BIT];               // see [RULE_21]
      state_next.wqm    = flow_high_word[WQM_BIT];               // see [RULE_22]
      state_next.bar    = flow_high_word[BAR_BIT];               // see [RULE_23]
      state_next.conflict = flow_high_word[WQM_BIT] && flow_high_word[VPM_BIT];
      // Call count read as 0..31; bit 15 is ignored here
      state_next.cskip  = (opc == OPC_CALL) && (depth_sum > (DEPTH_W+1)'(CALL_DEPTH_MAX)); // see [RULE_18]
      state_next.cdepth = (opc == OPC_CALL && !state_next.cskip) ? depth_sum[DEPTH_W-1:0]
                                                                 : call_depth;
      state_next.ws     = is_sync;
      state_next.illegal = 1'b0;
      state_next.misalign = 1'b0;
      if (is_sync) begin
        state_next.caddr = '0;
        state_next.jaddr = '0;
        state_next.tsel  = '0;
        state_next.tconst = 1'b0;
        state_next.telem = '0;
        state_next.tidx  = 1'b0;
        state_next.tidx_sel = 1'b0;
        state_next.val   = flow_low_word[VALUE_LSB +: VALUE_W];    // see [RULE_08]
        state_next.rsrc  = rsrc_fld;                               // see [RULE_09]
        state_next.sgn   = flow_low_word[SIGN_BIT];                // see [RULE_10]
        state_next.vim   = cfd_vim_t'(flow_low_word[VIM_LSB +: MODE_W]);   // see [RULE_11]
        state_next.rim   = cfd_rim_t'(flow_low_word[RIM_LSB +: MODE_W]);   // see [RULE_12]
        state_next.wsop  = cfd_wsop_t'(flow_low_word[WSOP_LSB +: MODE_W]); // see [RULE_13]
        // Upper resource half only exists with two engines
        state_next.illegal = (state_next.rim == rsrc_invalid)      // see [RULE_26]
                          || (SHADER_ENGINES == 1 && rsrc_fld[RSRC_W-1]);
      end else begin
        state_next.val   = '0;
        state_next.rsrc  = '0;
        state_next.sgn   = 1'b0;
        state_next.vim   = load_from_instr;
        state_next.rim   = rsrc_no_index;
        state_next.wsop  = semaphore_signal;
        state_next.caddr = program_base_register + clause_off;     // see [RULE_04]
        state_next.jaddr = program_base_register + jump_off;
        state_next.tsel  = flow_low_word[TSEL_LSB +: TSEL_W];
        state_next.tconst   = 1'b0;
        state_next.telem    = '0;
        state_next.tidx     = 1'b0;
        state_next.tidx_sel = 1'b0;
        if (opc == OPC_TABLE_JUMP) begin
          // Element and index picks stay zero where they do not apply
          unique case (state_next.tsel) inside
            [TSEL_CONST_A:TSEL_CONST_D]: begin
              state_next.tconst = 1'b1;                            // see [RULE_06]
              state_next.telem  = state_next.tsel[1:0];
            end
            TSEL_INDEX0: begin
              state_next.tidx = 1'b1;
            end
            TSEL_INDEX1: begin
              state_next.tidx     = 1'b1;
              state_next.tidx_sel = 1'b1;
            end
            default: begin
              state_next.illegal = 1'b1;                           // see [RULE_26]
            end
          endcase
        end
        // Report producer slips on fetch clause placement
        state_next.misalign = is_fetch &&
          (state_next.caddr[$clog2(FETCH_ALIGN)-1:0] != '0);      // see [RULE_05]
      end
    end else begin
      state_next.pend  = 1'b0;
      state_next.cskip = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_reg <= state_next;
  end

  assign dec_valid               = state_reg.valid;
  assign flow_opcode             = state_reg.opc;
  assign pop_count               = state_reg.pop;
  assign flow_constant_select    = state_reg.cnst;
  assign pixel_test_select       = state_reg.test;
  assign count_raw               = state_reg.cnt;
  assign clause_length           = state_reg.len;
  assign stream_id               = state_reg.stream;
  assign valid_pixel_mode        = state_reg.vpm;
  assign final_instruction_flag  = state_reg.eop;
  assign all_lanes_forced        = state_reg.wqm;
  assign barrier_wait            = state_reg.bar;
  assign program_end             = state_reg.pend & state_reg.valid;
  assign call_skip               = state_reg.cskip & state_reg.valid;
  assign call_depth_next         = state_reg.cdepth;
  assign clause_address          = state_reg.caddr;
  assign jump_address            = state_reg.jaddr;
  assign table_source_select     = state_reg.tsel;
  assign table_uses_const        = state_reg.tconst;
  assign table_const_element     = state_reg.telem;
  assign table_uses_index        = state_reg.tidx;
  assign table_index_sel         = state_reg.tidx_sel;
  assign wave_sync_valid         = state_reg.ws;
  assign load_value              = state_reg.val;
  assign value_signed            = state_reg.sgn;
  assign resource_index          = state_reg.rsrc;
  assign load_value_override     = state_reg.vim;
  assign resource_index_override = state_reg.rim;
  assign wave_sync_operation     = state_reg.wsop;
  assign illegal_encoding        = state_reg.illegal;
  assign fetch_misaligned        = state_reg.misalign;
  assign mode_conflict           = state_reg.conflict;

endmodule

`default_nettype wire

// file: testbench/cfd_decoder_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_decoder_chk
  import cfd_pkg::*;
(
  input wire logic                   ref_clk, srst, instr_valid, dec_valid,
  input wire logic [WORD_W-1:0]      flow_low_word, flow_high_word,
  input wire logic [BYTE_ADDR_W-1:0] program_base_register, jump_address,
  input wire logic [DEPTH_W-1:0]     call_depth,
  input wire logic [OPC_W-1:0]       flow_opcode,
  input wire logic [COUNT_W-1:0]     count_raw,
  input wire logic [COUNT_W:0]       clause_length,
  input wire logic                   final_instruction_flag, program_end, call_skip,
  input wire logic                   wave_sync_valid, mode_conflict,
  input wire logic [VALUE_W-1:0]     load_value,
  input wire logic [RSRC_W-1:0]      resource_index
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [7:0] opc = flow_high_word[29:22];
  a_answer_one_cycle: assert property (instr_valid |=> dec_valid)
    else $error("answer missing one cycle after request");
  a_idle_no_answer: assert property (!instr_valid |=> !dec_valid)
    else $error("answer without request");
  a_opcode_field: assert property (instr_valid |=> flow_opcode == $past(opc))
    else $error("opcode not taken from high bits 29:22");
  a_clause_len: assert property (
    dec_valid |-> clause_length == {1'b0, count_raw} + 7'h01)
    else $error("clause length not count plus one");
  a_end_pulse: assert property (
    program_end == (dec_valid && final_instruction_flag))
    else $error("program end pulse wrong");
  a_jump_target: assert property (
    instr_valid && opc != OPC_WAVE_SYNC |=>
    jump_address == $past(program_base_register + {flow_low_word[23:0], 3'b000}))
    else $error("jump address wrong");
  a_sync_fields: assert property (
    instr_valid && opc == OPC_WAVE_SYNC |=> wave_sync_valid &&
    load_value == $past(flow_low_word[9:0]) && resource_index == $past(flow_low_word[20:16]))
    else $error("wave sync fields wrong");
  a_call_skip: assert property (instr_valid && opc == OPC_CALL |=>
    call_skip == $past(call_depth + flow_high_word[14:10] > 32))
    else $error("call skip decision wrong");
  a_mode_clash: assert property (instr_valid |=>
    mode_conflict == $past(flow_high_word[20] & flow_high_word[30]))
    else $error("mode conflict flag wrong");
  c_sync: cover property (dec_valid && wave_sync_valid);
  c_skip: cover property (call_skip);
  c_end: cover property (program_end);
endmodule
bind cfd_decoder cfd_decoder_chk u_cfd_decoder_chk (.*);
`default_nettype wire

// file: testbench/cfd_fetch_model.sv
`timescale 1ns/1ns
`default_nettype none
module cfd_fetch_model
  import cfd_pkg::*;
(
  input  wire logic                   req,
  input  wire logic                   skew,
  input  wire logic [PAIR_W-1:0]      req_pair,
  input  wire logic [BYTE_ADDR_W-1:0] req_base,
  output logic                        instr_valid,
  output logic [WORD_W-1:0]           flow_low_word,
  output logic [WORD_W-1:0]           flow_high_word,
  output logic [BYTE_ADDR_W-1:0]      program_base_register
);
  logic fetch;
  always_comb begin
    fetch = req_pair[61:54] inside {OPC_TEX_CLAUSE, OPC_VTX_CLAUSE, OPC_TEX_ACK, OPC_VTX_ACK};
    instr_valid = req;
    {flow_high_word, flow_low_word} = req_pair;
    program_base_register = req_base;
    flow_high_word[19:16] = 4'h0;
    // Misaligned fetch only when the bench asks for it
    if (fetch && !skew) begin
      flow_low_word[0] = 1'b0;
      program_base_register[3:0] = 4'h0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/cfd_decoder_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module cfd_decoder_tb;
  import cfd_pkg::*;
  typedef struct packed {
    logic [42:0] com; logic [77:0] low; logic [22:0] sync; logic [3:0] flg;
  } cfd_exp_t;
  logic ref_clk = 0, srst = 1, req = 0, skew = 0;
  logic [63:0] pair = '0;
  logic [34:0] base = '0;
  logic [5:0] depth = '0;
  logic [31:0] seed = 32'h1563;
  int fails = 0, num_checks = 0;
  cfd_exp_t q[$];
  cfd_exp_t e;
  wire instr_valid, dec_valid;
  wire [31:0] flow_low_word, flow_high_word;
  wire [34:0] program_base_register;
  wire [42:0] o_com;
  wire [77:0] o_low;
  wire [22:0] o_sync;
  wire [3:0] o_flg;
  always #10 ref_clk = ~ref_clk;
  cfd_fetch_model u_cfd_fetch_model (.req(req), .skew(skew), .req_pair(pair), .req_base(base),
    .instr_valid(instr_valid), .flow_low_word(flow_low_word),
    .flow_high_word(flow_high_word), .program_base_register(program_base_register));
  cfd_decoder u_cfd_decoder (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid),
    .flow_low_word(flow_low_word), .flow_high_word(flow_high_word),
    .program_base_register(program_base_register), .call_depth(depth), .dec_valid(dec_valid),
    .flow_opcode(o_com[42:35]), .pop_count(o_com[34:32]), .flow_constant_select(o_com[31:27]),
    .pixel_test_select(o_com[26:25]), .count_raw(o_com[24:19]), .clause_length(o_com[18:12]),
    .stream_id(o_com[11]), .valid_pixel_mode(o_com[10]), .final_instruction_flag(o_com[9]),
    .all_lanes_forced(o_com[8]), .barrier_wait(o_com[7]), .call_skip(o_com[6]),
    .call_depth_next(o_com[5:0]), .clause_address(o_low[77:43]), .jump_address(o_low[42:8]),
    .table_source_select(o_low[7:5]), .table_uses_const(o_low[4]),
    .table_const_element(o_low[3:2]), .table_uses_index(o_low[1]), .table_index_sel(o_low[0]),
    .wave_sync_valid(o_sync[22]), .load_value(o_sync[21:12]), .value_signed(o_sync[11]),
    .resource_index(o_sync[10:6]), .load_value_override(o_sync[5:4]),
    .resource_index_override(o_sync[3:2]), .wave_sync_operation(o_sync[1:0]),
    .program_end(o_flg[3]), .illegal_encoding(o_flg[2]), .fetch_misaligned(o_flg[1]),
    .mode_conflict(o_flg[0]));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic cfd_exp_t predict(logic [63:0] p, logic [34:0] b, logic [5:0] d);
    logic [31:0] l, h;
    logic [7:0] op;
    logic sy, sk, tj;
    logic [34:0] a;
    logic [2:0] ts;
    int s;
    cfd_exp_t x;
    {h, l} = p;
    op = h[29:22];
    sy = op == OPC_WAVE_SYNC;
    tj = op == OPC_TABLE_JUMP;
    s = d + h[14:10];
    sk = op == OPC_CALL && s > 32;
    a = sy ? '0 : b + {l[23:0], 3'b000};
    ts = sy ? 3'h0 : l[26:24];
    x.com = {op, h[2:0], h[7:3], h[9:8], h[15:10], {1'b0, h[15:10]} + 7'h01,
      op inside {OPC_EMIT, OPC_EMIT_CUT, OPC_CUT} && h[10], h[20], h[21], h[30], h[31],
      sk, (op == OPC_CALL && !sk) ? 6'(s) : d};
    x.low = {a, a, ts, tj && ts < 3'h4, (tj && ts < 3'h4) ? ts[1:0] : 2'h0,
      tj && ts inside {3'h4, 3'h5}, tj && ts == 3'h5};
    x.sync = sy ? {1'b1, l[9:0], l[25], l[20:16], l[27:26], l[29:28], l[31:30]} : '0;
    x.flg = {h[21], sy && (l[29:28] == 2'h3 || l[20:16] > 5'h0F) || tj && ts > 3'h5,
      op inside {OPC_TEX_CLAUSE, OPC_VTX_CLAUSE, OPC_TEX_ACK, OPC_VTX_ACK} && a[3:0] != 4'h0,
      h[20] & h[30]};
    return x;
  endfunction
  task automatic send(logic [63:0] p, logic [5:0] d);
    @(negedge ref_clk);
    req = 1'b1;
    pair = p;
    depth = d;
    base = 35'({rnd(), rnd()});
    #1 q.push_back(predict({flow_high_word, flow_low_word}, program_base_register, depth));
  endtask
  // Released lines flip to the inverse each idle cycle, so every second one shows the last pair again
  task automatic idle(int n);
    repeat (n) begin
      @(negedge ref_clk);
      req = 1'b0;
      pair = ~pair;
    end
  endtask
  function automatic logic [63:0] with_op(logic [7:0] op);
    logic [63:0] p;
    p = {rnd(), rnd()};
    p[61:54] = op;
    return p;
  endfunction
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    if (dec_valid === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("mismatch answer exp none got one");
      end else begin
        e = q.pop_front();
        `CHK("fields", e.com[42:19], o_com[42:19])
        `CHK("clause", e.com[18:7], o_com[18:7])
        `CHK("call", e.com[6:0], o_com[6:0])
        `CHK("lowword", e.low, o_low)
        `CHK("wsval", e.sync[22:11], o_sync[22:11])
        `CHK("wsidx", e.sync[10:0], o_sync[10:0])
        `CHK("flags", e.flg, o_flg)
      end
    end
  end
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    logic [63:0] p;
    logic [7:0] ops[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h15, 8'h16, 8'h17,
                            8'h1B, 8'h1C, 8'h1D, 8'h1E};
    int cd[4][2] = '{'{32, 0}, '{1, 31}, '{2, 31}, '{32, 1}};
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    `CHK("reset", '0, {o_com, o_low, o_sync, o_flg, dec_valid})
    foreach (ops[i]) repeat (4) send(with_op(ops[i]), 6'(rnd() % 33));
    for (int i = 0; i < 8; i++) begin
      p = with_op(OPC_TABLE_JUMP);
      p[26:24] = 3'(i);
      send(p, 6'h00);
    end
    for (int i = 0; i < 4; i++) begin
      p = with_op(OPC_WAVE_SYNC);
      p[31:26] = {2'(i), 2'(i), 2'(3 - i)};
      send(p, 6'h00);
    end
    foreach (cd[i]) begin
      p = with_op(OPC_CALL);
      p[46:42] = 5'(cd[i][1]);
      send(p, 6'(cd[i][0]));
    end
    skew = 1'b1;
    p = with_op(OPC_TEX_CLAUSE);
    p[0] = 1'b1;
    send(p, 6'h00);
    // Keep the skew until the decoder has taken the word
    @(posedge ref_clk) #1 skew = 1'b0;
    repeat (200) begin
      send(with_op(8'(rnd() % 32)), 6'(rnd() % 33));
      if (rnd() % 4 == 0) idle(1 + rnd() % 3);
    end
    idle(2);
    @(negedge ref_clk) srst = 1'b1;
    @(negedge ref_clk) srst = 1'b0;
    `CHK("midreset", '0, {o_com, o_low, o_sync, o_flg, dec_valid})
    send(with_op(OPC_WAVE_SYNC), 6'h00);
    idle(3);
    `CHK("drained", 0, q.size())
    stop_test();
  end
endmodule
`default_nettype wire
